// >>> logic/timer_capture_restart_compare.sv
// Timer with capture-restart and compare modes
`timescale 1ns/1ps
`include "timer_defines.svh"
module timer_capture_restart_compare
#(
  parameter int PRE_W = `TMR_PRE_WIDTH
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Control 0 and 1
  input  wire logic             enable_i,
  input  wire logic [2:0]       timer_mode_field_i,
  input  wire logic             timer_mode_high_bit_i,
  input  wire logic [1:0]       interrupt_source_select_i,
  input  wire logic             capture_falling_i,
  input  wire logic [PRE_W-1:0] prescale_sel_i,
  input  wire logic             out_alt_en_i,
  // Count and capture writes, reload value
  input  wire logic             count_wr_i,
  input  wire timer_pkg::count_t count_wdata_i,
  input  wire timer_pkg::count_t reload_i,
  input  wire logic             cap_wr_i,
  input  wire timer_pkg::count_t cap_wdata_i,
  // Pins
  input  wire logic             timer_in_i,
  output logic                  timer_out_o,
  output logic                  timer_out_oe_o,
  // Status
  output timer_pkg::count_t     count_o,
  output timer_pkg::count_t     capture_o,
  output logic                  capture_flag_o,
  output logic                  irq_o
);
  import timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode and prescaler

  wire [3:0] mode_code_w = {timer_mode_high_bit_i, timer_mode_field_i};
  tmr_mode_t mode_w;
  assign mode_w = (mode_code_w == `TMR_MODE_CAPRST)  ? MODE_CAPRST  :
                  (mode_code_w == `TMR_MODE_COMPARE) ? MODE_COMPARE : MODE_OFF;

  logic [7:0] pre_cnt_q;
  wire  [7:0] pre_div_w  = 8'((9'h1 << prescale_sel_i) - 9'h1);
  wire        compare_w  = (mode_w == MODE_COMPARE);
  wire        run_w      = enable_i && (mode_w != MODE_OFF);
  // Compare mode uses the system clock directly
  wire        tick_w     = run_w && (compare_w || pre_cnt_q >= pre_div_w);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pre_cnt_q <= 8'h00;
    else
      pre_cnt_q <= (!run_w || tick_w) ? 8'h00 : pre_cnt_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture edge

  event_if ev ();
  edge_detect u_edge
  (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (timer_in_i),
    .falling_i (capture_falling_i),
    .arm_i     (run_w && !compare_w),
    .ev        (ev)
  );

  ////////////////////////////////////////////////////////////////////////
  // Counter, capture and events

  count_t cnt_q;
  count_t cap_q;
  logic   flag_q;
  logic   out_q;
  logic   irq_q;

  wire cap_ev_w   = ev.edge_hit && (mode_w == MODE_CAPRST) && enable_i;
  wire match_w    = tick_w && (cnt_q == reload_i);
  wire reload_w   = match_w && !compare_w && !cap_ev_w;
  wire cmp_hit_w  = match_w && compare_w;
  wire irq_cap_w  = cap_ev_w && (interrupt_source_select_i != `TMR_ISRC_RELOAD);
  wire irq_rel_w  = reload_w && (interrupt_source_select_i != `TMR_ISRC_CAP);

  count_t cnt_d;
  assign cnt_d = count_wr_i ? count_wdata_i :
                 (cap_ev_w || reload_w) ? `TMR_RESTART_VAL :
                 (tick_w && cnt_q == `TMR_MAX_VAL) ? `TMR_WRAP_VAL :
                 tick_w ? count_t'(cnt_q + 16'h0001) : cnt_q;

  count_t cap_d;
  assign cap_d = cap_ev_w ? cnt_q : (cap_wr_i ? cap_wdata_i : cap_q);

  wire flag_d = cap_ev_w ? 1'b1 : (reload_w ? 1'b0 : flag_q);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q  <= `TMR_CNT_RESET;
      cap_q  <= `TMR_CAP_RESET;
      flag_q <= 1'b0;
      out_q  <= 1'b0;
      irq_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      cap_q  <= cap_d;
      flag_q <= flag_d;
      out_q  <= (cmp_hit_w && out_alt_en_i) ? ~out_q : out_q;
      irq_q  <= irq_cap_w || irq_rel_w || cmp_hit_w;
    end
  end

  logic oe_q;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      oe_q <= 1'b0;
    else
      oe_q <= out_alt_en_i;
  end

  assign count_o        = cnt_q;
  assign capture_o      = cap_q;
  assign capture_flag_o = flag_q;
  assign irq_o          = irq_q;
  assign timer_out_o    = out_q;
  assign timer_out_oe_o = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_reload;
    !count_wr_i && reload_w;
  endsequence

  sequence s_restart;
    cnt_q == `TMR_RESTART_VAL;
  endsequence

  chk_reload_restart : assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_reload |=> s_restart)
    else $error("reload did not restart count at 0001");

  chk_reload_flag : assert property (@(posedge clk_i) disable iff (!nrst_i)
    reload_w |=> !capture_flag_o)
    else $error("capture flag not cleared on reload");

  chk_mode_decode : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (mode_w == MODE_CAPRST) |-> {timer_mode_high_bit_i, timer_mode_field_i} == `TMR_MODE_CAPRST)
    else $error("mode decode mismatch");

  chk_capture_store : assert property (@(posedge clk_i) disable iff (!nrst_i)
    cap_ev_w |=> capture_o == $past(cnt_q) && capture_flag_o)
    else $error("capture value not stored");

  chk_reload_keeps : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reload_w && !cap_wr_i) |=> $stable(capture_o))
    else $error("reload changed capture bytes");

  chk_irq_source : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reload_w && interrupt_source_select_i == `TMR_ISRC_CAP && !cap_ev_w) |=> !irq_o)
    else $error("reload interrupt not suppressed");

  chk_irq_default : assert property (@(posedge clk_i) disable iff (!nrst_i)
    ((cap_ev_w || reload_w) && interrupt_source_select_i == `TMR_ISRC_BOTH) |=> irq_o)
    else $error("default interrupt missing");

  chk_prescale_hold : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (run_w && !compare_w && !tick_w && !count_wr_i && !cap_ev_w) |=> $stable(count_o))
    else $error("counter moved between prescale ticks");

  chk_compare_cont : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cmp_hit_w && !count_wr_i && cnt_q != `TMR_MAX_VAL)
    |=> irq_o && count_o == $past(cnt_q) + 16'h0001)
    else $error("compare match did not continue counting");

  chk_out_toggle : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cmp_hit_w && out_alt_en_i) |=> timer_out_o != $past(timer_out_o))
    else $error("output pin did not toggle");

  chk_wrap : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (compare_w && tick_w && cnt_q == `TMR_MAX_VAL && !count_wr_i) |=> count_o == `TMR_WRAP_VAL)
    else $error("compare mode did not wrap");

  ////////////////////////////////////////////////////////////////////////
  // Checks: capture path and flag

  sequence s_capture;
    cap_ev_w && !count_wr_i;
  endsequence

  sequence s_tick_caprst;
    tick_w && run_w && !compare_w;
  endsequence

  chk_capture_restart : assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_capture |=> s_restart)
    else $error("capture did not restart count at 0001");

  chk_capture_flag : assert property (@(posedge clk_i) disable iff (!nrst_i)
    cap_ev_w |=> capture_flag_o)
    else $error("capture did not set flag");

  chk_capture_wins : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cap_ev_w && match_w && !count_wr_i)
    |=> count_o == `TMR_RESTART_VAL && capture_flag_o)
    else $error("capture did not win over reload");

  chk_flag_rise : assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(capture_flag_o) |-> $past(cap_ev_w))
    else $error("flag set without capture");

  chk_flag_drop : assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(capture_flag_o) |-> $past(reload_w))
    else $error("flag cleared without reload");

  chk_flag_keep : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!cap_ev_w && !reload_w) |=> $stable(capture_flag_o))
    else $error("flag changed with no event");

  chk_cap_keep : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!cap_ev_w && !cap_wr_i) |=> $stable(capture_o))
    else $error("capture bytes changed with no event");

  chk_cap_write : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cap_wr_i && !cap_ev_w) |=> capture_o == $past(cap_wdata_i))
    else $error("capture bytes write lost");

  chk_reload_value : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_tick_caprst and (cnt_q == reload_i && !cap_ev_w && !count_wr_i))
    |=> count_o == `TMR_RESTART_VAL && !capture_flag_o)
    else $error("reload value reached without restart");

  ////////////////////////////////////////////////////////////////////////
  // Checks: interrupt source

  chk_cap_irq : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cap_ev_w && interrupt_source_select_i != `TMR_ISRC_RELOAD) |=> irq_o)
    else $error("capture interrupt missing");

  chk_cap_irq_mask : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cap_ev_w && interrupt_source_select_i == `TMR_ISRC_RELOAD) |=> !irq_o)
    else $error("capture interrupt not suppressed");

  chk_rel_irq : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (reload_w && interrupt_source_select_i != `TMR_ISRC_CAP) |=> irq_o)
    else $error("reload interrupt missing");

  chk_irq_cause : assert property (@(posedge clk_i) disable iff (!nrst_i)
    irq_o |-> $past(cap_ev_w || reload_w || cmp_hit_w))
    else $error("interrupt with no cause");

  ////////////////////////////////////////////////////////////////////////
  // Checks: counting, mode and output pin

  chk_stop_hold : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!run_w && !count_wr_i) |=> $stable(count_o))
    else $error("stopped counter moved");

  chk_stop_quiet : assert property (@(posedge clk_i) disable iff (!nrst_i)
    !run_w |=> !irq_o && $stable(timer_out_o))
    else $error("stopped timer raised event");

  chk_prescale_gap : assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_tick_caprst ##1 (run_w && !compare_w && prescale_sel_i != '0) |-> !tick_w)
    else $error("prescale ticks too close");

  chk_capture_step : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_tick_caprst and (!match_w && !cap_ev_w && !count_wr_i && cnt_q != `TMR_MAX_VAL))
    |=> count_o == $past(cnt_q) + 16'h0001)
    else $error("capture mode tick did not advance");

  chk_compare_step : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (compare_w && run_w && !count_wr_i && cnt_q != `TMR_MAX_VAL)
    |=> count_o == $past(cnt_q) + 16'h0001)
    else $error("compare mode did not count every clock");

  chk_cmp_irq : assert property (@(posedge clk_i) disable iff (!nrst_i)
    cmp_hit_w |=> irq_o && $stable(capture_flag_o))
    else $error("compare match interrupt missing");

  chk_cmp_irq_off : assert property (@(posedge clk_i) disable iff (!nrst_i)
    (compare_w && run_w && !match_w) |=> !irq_o)
    else $error("compare interrupt without match");

  chk_out_keep : assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(cmp_hit_w && out_alt_en_i) |=> $stable(timer_out_o))
    else $error("output pin moved without match");

  chk_oe_on : assert property (@(posedge clk_i) disable iff (!nrst_i)
    out_alt_en_i |=> timer_out_oe_o)
    else $error("output enable not raised");

  chk_oe_off : assert property (@(posedge clk_i) disable iff (!nrst_i)
    !out_alt_en_i |=> !timer_out_oe_o)
    else $error("output enable not dropped");
endmodule : timer_capture_restart_compare

// >>> pkg/timer_defines.svh
// Timer constants: mode and interrupt source codes, reset values, counts
//
// Notes on behaviour
// - Capture-restart: count reaching reload value restarts at 0001H without stopping.
// - Reload-caused interrupt clears capture_flag so causes can be told apart.
// - Mode comes from timer_mode_field plus timer_mode_high_bit.
// - Software picks rising or falling input edge for capture.
// - Capture writes count to capture bytes; reload leaves them unchanged.
// - By default both capture and reload raise the interrupt.
// - interrupt_source_select limits interrupt to capture only or reload only.
// - Capture-restart counter advances once per prescale system clock periods; compare mode counts every clock.
// - Compare mode counts up toward 16-bit value in reload registers.
// - Compare match raises interrupt and counting continues, no restart.
// - Output pin toggles on each compare match when output function enabled.
// - Compare mode: FFFFH wraps to 0000H and counting continues.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define TMR_WIDTH        16
`define TMR_RESTART_VAL  16'h0001
`define TMR_WRAP_VAL     16'h0000
`define TMR_MAX_VAL      16'hFFFF
`define TMR_CNT_RESET    16'h0000
`define TMR_CAP_RESET    16'h0000
`define TMR_RELOAD_RESET 16'hFFFF
`define TMR_PRE_WIDTH    3
`define TMR_MODE_CAPRST  4'h7
`define TMR_MODE_COMPARE 4'h3
`define TMR_ISRC_BOTH    2'h0
`define TMR_ISRC_CAP     2'h2
`define TMR_ISRC_RELOAD  2'h3

`endif

// >>> pkg/timer_pkg.sv
// Timer types
package timer_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_CAPRST, MODE_COMPARE} tmr_mode_t;
  typedef logic [15:0] count_t;
endpackage : timer_pkg

// >>> pkg/event_if.sv
// Event carrier between the edge detector and the timer core
`timescale 1ns/1ps
interface event_if;
  logic edge_hit;
  modport src (output edge_hit);
  modport dst (input edge_hit);
endinterface : event_if

// >>> logic/edge_detect.sv
// Capture edge qualifier for the timer input
`timescale 1ns/1ps
module edge_detect
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Input
  input  wire logic pin_i,
  input  wire logic falling_i,
  input  wire logic arm_i,
  // Event out
  event_if.src      ev
);
  logic prev_q;
  logic hit_q;
  wire  rise_w = pin_i & ~prev_q;
  wire  fall_w = ~pin_i & prev_q;
  wire  sel_w  = falling_i ? fall_w : rise_w;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prev_q <= 1'b0;
      hit_q  <= 1'b0;
    end
    else
    begin
      prev_q <= pin_i;
      hit_q  <= sel_w & arm_i;
    end
  end

  assign ev.edge_hit = hit_q;

  chk_edge_polarity : assert property (@(posedge clk_i) disable iff (!nrst_i)
    hit_q |-> $past(arm_i) && ($past(falling_i) ? $fell($past(pin_i))
                                             : $rose($past(pin_i))))
    else $error("capture edge fired on wrong polarity");
endmodule : edge_detect

// >>> tb/pin_source.sv
// Far-side signal source driving the timer input pin
`timescale 1ns/1ps
module pin_source
(
  // Clock
  input  wire logic clk_i,
  // Requested level and pin
  input  wire logic lvl_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;
  // Pin moves just after the edge, like a real driver
  always @(posedge clk_i) pin_o <= #1 lvl_i;
endmodule : pin_source

// >>> tb/timer_capture_restart_compare_test.sv
// Self-checking bench for the capture-restart and compare timer
`timescale 1ns/1ps
module timer_capture_restart_compare_test;
  import timer_pkg::*;
  logic       clk_i, nrst_i, en, hi, fall, oen, kwr, cwr, lvl, pin, tout, toe, flag, irq;
  logic [2:0] fld, sel;
  logic [1:0] isrc;
  count_t     kdat, cdat, rel, cnt, cap, c;
  int         failures, tests_run;

  pin_source src (.clk_i(clk_i), .lvl_i(lvl), .pin_o(pin));
  timer_capture_restart_compare dut (.clk_i(clk_i), .nrst_i(nrst_i), .enable_i(en),
    .timer_mode_field_i(fld), .timer_mode_high_bit_i(hi), .interrupt_source_select_i(isrc),
    .capture_falling_i(fall), .prescale_sel_i(sel), .out_alt_en_i(oen), .count_wr_i(kwr),
    .count_wdata_i(kdat), .reload_i(rel), .cap_wr_i(cwr), .cap_wdata_i(cdat),
    .timer_in_i(pin), .timer_out_o(tout), .timer_out_oe_o(toe), .count_o(cnt),
    .capture_o(cap), .capture_flag_o(flag), .irq_o(irq));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input count_t got, input count_t exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic wait_val(input count_t v);
    for (int k = 0; k < 80 && cnt !== v; k++) tick(1);
    chk(cnt, v);
  endtask : wait_val

  task automatic wait_irq();
    for (int k = 0; k < 8 && irq !== 1'b1; k++) tick(1);
    chk(16'(irq), 16'h0001);
  endtask : wait_irq

  task automatic no_irq(input int n);
    int seen;
    seen = 0;
    repeat (n)
    begin
      tick(1);
      seen += (irq !== 1'b0);
    end
    chk(16'(seen), 16'h0000);
  endtask : no_irq

  task automatic setup(input logic [3:0] m, input logic [1:0] s, input logic f,
                       input count_t st, input count_t rl);
    {en, hi, fld, isrc, fall, lvl} = {1'b0, m, s, f, f};
    {kwr, kdat, cwr, cdat, rel} = {1'b1, st, 1'b1, 16'h0000, rl};
    tick(2);
    {kwr, cwr, en} = 3'b001;
    tick(2);
  endtask : setup
  ////////////////////////////////////////////////////////////////////////
  task automatic capture_then_reload(input logic f);
    setup(4'h7, 2'h0, f, 16'h0001, 16'h0040);
    lvl = !f;
    wait_irq();
    chk(16'(flag), 16'h0001);
    chk(cnt, 16'h0001);
    chk(16'(cap == 16'h0000), 16'h0000);
    c = cap;
    lvl = f;
    no_irq(6);
    wait_val(16'h0040);
    tick(1);
    chk(16'(irq), 16'h0001);
    chk(cnt, 16'h0001);
    chk(16'(flag), 16'h0000);
    chk(cap, c);
  endtask : capture_then_reload

  task automatic source_select();
    setup(4'h7, 2'h2, 1'b0, 16'h0001, 16'h0008);
    no_irq(12);
    lvl = 1'b1;
    wait_irq();
    setup(4'h7, 2'h3, 1'b0, 16'h0001, 16'h0040);
    lvl = 1'b1;
    no_irq(6);
    chk(16'(flag), 16'h0001);
    wait_val(16'h0040);
    tick(1);
    chk(16'(irq), 16'h0001);
  endtask : source_select

  task automatic prescale_and_stop();
    sel = 3'h2;
    setup(4'h7, 2'h0, 1'b0, 16'h0001, 16'hFFFF);
    c = cnt;
    tick(8);
    chk(cnt, c + 16'h0002);
    sel = 3'h0;
    setup(4'h0, 2'h0, 1'b0, 16'h0001, 16'hFFFF);
    tick(4);
    chk(cnt, 16'h0001);
  endtask : prescale_and_stop

  task automatic compare_mode();
    oen = 1'b1;
    setup(4'h3, 2'h0, 1'b0, 16'h000E, 16'h0010);
    chk(16'(toe), 16'h0001);
    wait_val(16'h0010);
    tick(1);
    chk(16'(irq), 16'h0001);
    chk(cnt, 16'h0011);
    chk(16'(tout), 16'h0001);
    {kwr, kdat} = {1'b1, 16'hFFFD};
    tick(1);
    kwr = 1'b0;
    wait_val(16'hFFFF);
    tick(1);
    chk(cnt, 16'h0000);
    wait_val(16'h0010);
    tick(1);
    chk(16'(tout), 16'h0000);
  endtask : compare_mode
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  initial
  begin
    {nrst_i, en, hi, fld, isrc, fall, sel, oen, kwr, cwr, lvl} = 0;
    {kdat, cdat, rel} = 0;
    tick(2);
    nrst_i = 1'b1;
    capture_then_reload(1'b0);
    capture_then_reload(1'b1);
    source_select();
    prescale_and_stop();
    compare_mode();
    summarize();
  end

  initial
  begin
    #100000;
    failures++;
    summarize();
  end
endmodule : timer_capture_restart_compare_test
